/* File: design/hbridge_apb_regs.sv */
`timescale 1ns/100ps
`default_nettype none

// APB slave for control, status and interrupt registers
module hbridge_apb_regs (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [hbridge_pkg::ADDR_W-1:0] paddr,
    input wire logic [hbridge_pkg::DATA_W-1:0] pwdata,
    output logic [hbridge_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Block side
    output logic [3:0] ctrl,
    input wire logic [5:0] status,
    input wire logic [hbridge_pkg::EV_W-1:0] events,
    output logic irq
);

    logic [3:0] ctrl_q;
    logic [hbridge_pkg::EV_W-1:0] ist_q;
    logic [hbridge_pkg::EV_W-1:0] ien_q;
    logic [hbridge_pkg::DATA_W-1:0] rdata_d;
    logic [hbridge_pkg::DATA_W-1:0] prdata_q;
    logic irq_q;
    logic err_d;
    logic pslverr_q;

    // Decode
    wire access = psel && penable;
    wire wr = access && pwrite;
    wire hit_ctrl = (paddr == hbridge_pkg::CTRL_ADDR);
    wire hit_stat = (paddr == hbridge_pkg::STATUS_ADDR);
    wire hit_ist = (paddr == hbridge_pkg::IRQ_STAT_ADDR);
    wire hit_clr = (paddr == hbridge_pkg::IRQ_CLR_ADDR);
    wire hit_en = (paddr == hbridge_pkg::IRQ_EN_ADDR);
    wire [hbridge_pkg::EV_W-1:0] clr_mask =
        (wr && hit_clr) ? pwdata[hbridge_pkg::EV_W-1:0] : '0;

    // Read mux; clear register reads as zero, unmapped errors
    always_comb begin
        rdata_d = '0;
        err_d = 1'b0;
        if (hit_ctrl) begin
            rdata_d[3:0] = ctrl_q;
        end else if (hit_stat) begin
            rdata_d[5:0] = status;
        end else if (hit_ist) begin
            rdata_d[hbridge_pkg::EV_W-1:0] = ist_q;
        end else if (hit_clr) begin
            rdata_d = '0;
        end else if (hit_en) begin
            rdata_d[hbridge_pkg::EV_W-1:0] = ien_q;
        end else begin
            err_d = 1'b1;
        end
    end

    // Registers; an event in the clear cycle stays set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= hbridge_pkg::CTRL_RESET;
            ist_q <= '0;
            ien_q <= '0;
            prdata_q <= '0;
            pslverr_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            if (wr && hit_ctrl) begin
                ctrl_q <= pwdata[3:0];
            end
            if (wr && hit_en) begin
                ien_q <= pwdata[hbridge_pkg::EV_W-1:0];
            end
            ist_q <= (ist_q & ~clr_mask) | events;
            prdata_q <= (psel && !penable && !pwrite) ? rdata_d : prdata_q;
            pslverr_q <= (psel && !penable) ? err_d : pslverr_q;
            irq_q <= |(((ist_q & ~clr_mask) | events) & ien_q);
        end
    end

    assign ctrl = ctrl_q;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign pready = 1'b1;
    assign irq = irq_q;

endmodule

`default_nettype wire

/* File: design/hbridge_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Each output follows its own drive input
// - Both inputs equal gives braking
// - Any disable tri-states outputs, flag low
// - Fault detection keeps running while disabled; here short detection needs an active bridge
// - Undervoltage tri-states, recovers by itself
// - Short or overtemperature latches outputs off
// - Latch cleared only by disable toggle
// - Clear on disable-high fall or disable-low rise
// - Restart after overtemp only below hysteresis
// - Fault flag is active-low open drain
// - Over-limit current is regulated, not latched
// - Limit hit gives fixed off time
// - Blanking window from each activation detects shorts
// - Blanking window about 16.5 us
// - Limit folds back hot, latch above 175 C
module hbridge_ctrl #(
    parameter int OFF_CYCLES = hbridge_pkg::OFF_CYCLES,
    parameter int BLANK_CYCLES = hbridge_pkg::BLANK_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB register port
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [hbridge_pkg::ADDR_W-1:0] paddr,
    input wire logic [hbridge_pkg::DATA_W-1:0] pwdata,
    output logic [hbridge_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Drive and disable pins
    input wire logic drive_in_a,
    input wire logic drive_in_b,
    input wire logic disable_hi_in,
    input wire logic disable_lo_n_in,
    // Analog monitor indications
    input wire logic undervoltage,
    input wire logic over_limit,
    input wire logic short_detect,
    input wire logic over_temp,
    input wire logic temp_below_hyst,
    input wire logic temp_foldback,
    // Bridge switch controls
    output logic high_on_a,
    output logic low_on_a,
    output logic high_on_b,
    output logic low_on_b,
    output logic limit_reduce,
    // Open-drain fault flag
    output logic fault_flag_n_out,
    output logic fault_flag_n_oe,
    // Interrupt
    output logic irq
);

    // Registered pins and their previous values
    logic a_q, b_q, dh_q, dl_q, dh_prev_q, dl_prev_q;
    // Latched faults
    logic short_lat_q, ot_lat_q, ot_wait_q;
    // Output flops
    logic ha_q, la_q, hb_q, lb_q, flag_oe_q, fold_q;
    logic active_q;
    logic [3:0] ctrl;
    logic [5:0] status;
    logic [hbridge_pkg::EV_W-1:0] events;
    logic off_busy, blank_busy, uv_q, lim_ev;

    hbridge_pkg::drive_t out_a, out_b;

    // Pins OR-combined with software overrides from the control register
    wire drv_a = a_q | ctrl[hbridge_pkg::CTRL_DRV_A];
    wire drv_b = b_q | ctrl[hbridge_pkg::CTRL_DRV_B];
    wire dis_hi = dh_q | ctrl[hbridge_pkg::CTRL_DIS_HI];
    wire dis_lo_n = dl_q & ctrl[hbridge_pkg::CTRL_DIS_LO_N];

    // Disable edges that clear the latch; pins only, so software
    // overrides cannot mask the controller's toggle
    wire clear_ev = (dh_prev_q && !dh_q) || (!dl_prev_q && dl_q);
    wire disabled = dis_hi || !dis_lo_n;
    wire latched = short_lat_q || ot_lat_q || ot_wait_q;
    wire protect = latched || undervoltage;
    wire bridge_on = !protect && !disabled && !off_busy;
    wire activate = bridge_on && !active_q;
    // Short seen only inside the blanking window after activation
    wire short_hit = short_detect && blank_busy && active_q;
    wire limit_hit = over_limit && active_q && !off_busy;

    // Drive decode per output
    function automatic hbridge_pkg::drive_t decode(input logic lvl,
                                                   input logic on);
        if (!on) begin
            decode = hbridge_pkg::DRV_OFF;
        end else if (lvl) begin
            decode = hbridge_pkg::DRV_HIGH;
        end else begin
            decode = hbridge_pkg::DRV_LOW;
        end
    endfunction

    assign out_a = decode(drv_a, bridge_on);
    assign out_b = decode(drv_b, bridge_on);

    // Input registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
            dh_q <= 1'b1;
            dl_q <= 1'b0;
            dh_prev_q <= 1'b1;
            dl_prev_q <= 1'b0;
        end else begin
            a_q <= drive_in_a;
            b_q <= drive_in_b;
            dh_q <= disable_hi_in;
            dl_q <= disable_lo_n_in;
            dh_prev_q <= dh_q;
            dl_prev_q <= dl_q;
        end
    end

    // Fault latches; overtemp detection runs regardless of disable state, short detection only while active
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            short_lat_q <= 1'b0;
            ot_lat_q <= 1'b0;
            ot_wait_q <= 1'b0;
            uv_q <= 1'b0;
        end else begin
            uv_q <= undervoltage;
            // New detections win over a clear in the same cycle
            if (short_hit) begin
                short_lat_q <= 1'b1;
            end else if (clear_ev) begin
                short_lat_q <= 1'b0;
            end
            if (over_temp) begin
                ot_lat_q <= 1'b1;
            end else if (clear_ev) begin
                ot_lat_q <= 1'b0;
            end
            // Cleared overtemp holds off until cooled past hysteresis
            if (over_temp) begin
                ot_wait_q <= 1'b0;
            end else if (clear_ev && ot_lat_q && !temp_below_hyst) begin
                ot_wait_q <= 1'b1;
            end else if (temp_below_hyst) begin
                ot_wait_q <= 1'b0;
            end
        end
    end

    // Off time after each limit hit, then a fresh activation
    hbridge_timer #(.W(hbridge_pkg::CNT_W)) u_off (
        .pclk(pclk),
        .presetn(presetn),
        .load(limit_hit),
        .count(hbridge_pkg::CNT_W'(OFF_CYCLES)),
        .busy(off_busy)
    );

    // Blanking window restarted at every activation
    hbridge_timer #(.W(hbridge_pkg::CNT_W)) u_blank (
        .pclk(pclk),
        .presetn(presetn),
        .load(activate),
        .count(hbridge_pkg::CNT_W'(BLANK_CYCLES)),
        .busy(blank_busy)
    );

    // Output stage flops; flag pulled low on fault or disable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ha_q <= 1'b0;
            la_q <= 1'b0;
            hb_q <= 1'b0;
            lb_q <= 1'b0;
            active_q <= 1'b0;
            flag_oe_q <= 1'b0;
            fold_q <= 1'b0;
        end else begin
            ha_q <= (out_a == hbridge_pkg::DRV_HIGH);
            la_q <= (out_a == hbridge_pkg::DRV_LOW);
            hb_q <= (out_b == hbridge_pkg::DRV_HIGH);
            lb_q <= (out_b == hbridge_pkg::DRV_LOW);
            active_q <= bridge_on;
            // Oe low means the pin is pulled low
            flag_oe_q <= !(protect || disabled);
            fold_q <= temp_foldback;
        end
    end

    assign lim_ev = limit_hit;
    assign events = {lim_ev, over_temp && !ot_lat_q,
                     short_hit && !short_lat_q, undervoltage && !uv_q};
    assign status = {disabled, flag_oe_q, off_busy, latched && ot_lat_q,
                     short_lat_q, undervoltage};

    hbridge_apb_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .ctrl(ctrl),
        .status(status),
        .events(events),
        .irq(irq)
    );

    assign high_on_a = ha_q;
    assign low_on_a = la_q;
    assign high_on_b = hb_q;
    assign low_on_b = lb_q;
    assign limit_reduce = fold_q;
    assign fault_flag_n_out = 1'b0;
    assign fault_flag_n_oe = flag_oe_q;

endmodule

`default_nettype wire

/* File: design/hbridge_pkg.sv */
package hbridge_pkg;

    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register byte addresses
    localparam logic [11:0] CTRL_ADDR = 12'h000;
    localparam logic [11:0] STATUS_ADDR = 12'h004;
    localparam logic [11:0] IRQ_STAT_ADDR = 12'h008;
    localparam logic [11:0] IRQ_CLR_ADDR = 12'h00c;
    localparam logic [11:0] IRQ_EN_ADDR = 12'h010;

    // Control register fields
    localparam int CTRL_DRV_A = 0;
    localparam int CTRL_DRV_B = 1;
    localparam int CTRL_DIS_HI = 2;
    localparam int CTRL_DIS_LO_N = 3;
    localparam logic [3:0] CTRL_RESET = 4'h8;

    // Status fields
    localparam int ST_UV = 0;
    localparam int ST_SHORT = 1;
    localparam int ST_OT = 2;
    localparam int ST_LIMIT = 3;
    localparam int ST_FLAG_N = 4;
    localparam int ST_DIS = 5;

    // Interrupt event bits
    localparam int EV_W = 4;
    localparam int EV_UV = 0;
    localparam int EV_SHORT = 1;
    localparam int EV_OT = 2;
    localparam int EV_LIMIT = 3;

    // Timing
    localparam int CLK_MHZ = 100;
    localparam int OFF_TIME_US = 20;
    localparam int BLANK_MIN_NS = 12000;
    localparam int BLANK_NOM_NS = 16500;
    localparam int CLK_NS = 10;
    localparam int OFF_CYCLES = OFF_TIME_US * CLK_MHZ;
    localparam int BLANK_CYCLES = (BLANK_NOM_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 16;

    // Per-output drive state
    typedef enum logic [1:0] {
        DRV_LOW,
        DRV_HIGH,
        DRV_OFF
    } drive_t;

endpackage

/* File: design/hbridge_timer.sv */
`timescale 1ns/100ps
`default_nettype none

// Down counter: load starts it, busy stays high until it reaches zero
module hbridge_timer #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic load,
    input wire logic [W-1:0] count,
    // State
    output logic busy
);

    logic [W-1:0] cnt_q;

    // Reload wins over counting so a retrigger restarts the window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= count;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign busy = (cnt_q != '0);

endmodule

`default_nettype wire

/* File: dv/hbridge_controller_model.sv */
`timescale 1ns/100ps
`default_nettype none

// Stands in for the outside controller and the flag pull-up
module hbridge_controller_model (
    // Bench commands
    input wire logic cmd_a,
    input wire logic cmd_b,
    input wire logic cmd_off,
    input wire logic cmd_use_lo,
    // Flag driver
    input wire logic fault_flag_n_out,
    input wire logic fault_flag_n_oe,
    // Pins
    output logic drive_in_a,
    output logic drive_in_b,
    output logic disable_hi_in,
    output logic disable_lo_n_in,
    output logic fault_flag_n
);
    // Polarity straight from the commands
    assign drive_in_a = cmd_a;
    assign drive_in_b = cmd_b;
    // One disable moves at a time, so its release is a clear edge
    assign disable_hi_in = cmd_off & ~cmd_use_lo;
    assign disable_lo_n_in = ~(cmd_off & cmd_use_lo);
    // Released flag reads high through the pull-up
    assign fault_flag_n = fault_flag_n_oe ? 1'b1 : fault_flag_n_out;
endmodule

`default_nettype wire

/* File: dv/hbridge_ctrl_assertions.sv */
`timescale 1ns/100ps
`default_nettype none

// Pin-level checks on the switches and the fault flag
module hbridge_ctrl_assertions #(
    parameter int OFF_CYCLES = 20,
    parameter int BLANK_CYCLES = 10
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pins and monitors
    input wire logic drive_in_a,
    input wire logic drive_in_b,
    input wire logic disable_hi_in,
    input wire logic disable_lo_n_in,
    input wire logic undervoltage,
    input wire logic over_limit,
    input wire logic over_temp,
    input wire logic temp_foldback,
    // Switches and flag
    input wire logic high_on_a,
    input wire logic low_on_a,
    input wire logic high_on_b,
    input wire logic low_on_b,
    input wire logic limit_reduce,
    input wire logic fault_flag_n_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Any closed switch means the bridge drives
    wire logic any_on = high_on_a | low_on_a | high_on_b | low_on_b;
    // Pins reach the switches two edges later
    sequence s_dis;
        (disable_hi_in || !disable_lo_n_in) ##2 1'b1;
    endsequence
    // Limit hit seen, then the bridge opens
    sequence s_hit;
        any_on && over_limit ##[1:3] !any_on;
    endsequence
    property p_follow_a;
        (high_on_a |-> $past(drive_in_a, 2)) and
            (low_on_a |-> !$past(drive_in_a, 2));
    endproperty
    property p_follow_b;
        (high_on_b |-> $past(drive_in_b, 2)) and
            (low_on_b |-> !$past(drive_in_b, 2));
    endproperty
    property p_dis;
        s_dis |-> !any_on && !fault_flag_n_oe;
    endproperty
    property p_uv;
        undervoltage [*3] |-> !any_on && !fault_flag_n_oe;
    endproperty
    property p_ot;
        over_temp [*3] |-> !any_on && !fault_flag_n_oe;
    endproperty
    property p_flag_on;
        any_on |-> fault_flag_n_oe;
    endproperty
    // Off time is far longer than eight cycles in every build
    property p_limit_hold;
        s_hit |=> !any_on [*8];
    endproperty
    property p_fold;
        $rose(temp_foldback) |-> ##[1:2] limit_reduce;
    endproperty
    a_follow_a: assert property (p_follow_a)
        else $error("switch a disagrees with its input");
    a_follow_b: assert property (p_follow_b)
        else $error("switch b disagrees with its input");
    a_dis: assert property (p_dis)
        else $error("disable did not open the bridge");
    a_uv: assert property (p_uv)
        else $error("low supply did not open the bridge");
    a_ot: assert property (p_ot)
        else $error("overheat did not open the bridge");
    a_flag_on: assert property (p_flag_on)
        else $error("bridge drives while flag pulled low");
    a_limit_hold: assert property (p_limit_hold)
        else $error("limit off time cut short");
    a_fold: assert property (p_fold)
        else $error("fold-back request missing");
endmodule

bind hbridge_ctrl hbridge_ctrl_assertions #(
    .OFF_CYCLES(OFF_CYCLES),
    .BLANK_CYCLES(BLANK_CYCLES)
) u_hbridge_ctrl_assertions (.*);

`default_nettype wire

/* File: dv/hbridge_ctrl_test.sv */
`timescale 1ns/100ps
`default_nettype none

module hbridge_ctrl_test;
    localparam int OFF_C = 20;
    localparam int BLANK_C = 10;
    // Half period of the fastest allowed drive PWM
    localparam int PWM_HALF = 5000;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic cmd_a, cmd_b, cmd_off, cmd_use_lo, irq, limit_reduce;
    logic undervoltage, over_limit, short_detect, over_temp;
    logic temp_below_hyst, temp_foldback, fault_flag_n;
    logic drive_in_a, drive_in_b, disable_hi_in, disable_lo_n_in;
    logic high_on_a, low_on_a, high_on_b, low_on_b;
    logic fault_flag_n_out, fault_flag_n_oe;
    int num_errors, samples_checked, seed, v, n;

    hbridge_ctrl #(
        .OFF_CYCLES(OFF_C),
        .BLANK_CYCLES(BLANK_C)
    ) u_hbridge_ctrl (.*);
    hbridge_controller_model u_hbridge_controller_model (.*);

    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        samples_checked++;
        if (s !== x) begin
            num_errors++;
            $display("CHECK FAILED %0t: saw %h want %h", $time, s, x);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask
    // One APB transfer; pready is waited for under a bound
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        r = prdata;
        e = pslverr;
        // A slave that never answers ends the run as a failure
        if (n == 40) begin
            num_errors++;
            results();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Wanted switch pair of one half-bridge
    function automatic logic [1:0] sw(input logic d, input logic en);
        return en ? {d, !d} : 2'b00;
    endfunction
    // Sampled mid-cycle so every update has landed
    task automatic outs(input logic en, input logic fl);
        @(negedge pclk);
        chk({high_on_a, low_on_a, high_on_b, low_on_b, fault_flag_n},
            {sw(cmd_a, en), sw(cmd_b, en), fl});
    endtask
    task automatic results();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Hang guard, well past the expected run length
    initial begin
        cyc(80000);
        num_errors++;
        results();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {cmd_a, cmd_b, cmd_off, cmd_use_lo} = '0;
        {undervoltage, over_limit, short_detect, over_temp} = '0;
        {temp_below_hyst, temp_foldback} = 2'b10;
        {presetn, num_errors, samples_checked} = '0;
        seed = 32'hb9c6c2ce;
        cyc(10);
        presetn <= 1'b1;
        // Unmapped word is refused and reads zero
        apb(1'b0, 12'h020, '0);
        chk(e, 1'b1);
        chk(r, 32'h0);
        apb(1'b1, hbridge_pkg::IRQ_EN_ADDR, 32'hf);
        // All four input pairs, then random ones, at the fastest PWM
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            @(posedge pclk);
            {cmd_a, cmd_b} <= (i < 4) ? i[1:0] : v[1:0];
            cyc(PWM_HALF);
            outs(1'b1, 1'b1);
        end
        // Each disable pin on its own
        for (int k = 0; k < 2; k++) begin
            @(posedge pclk);
            cmd_use_lo <= k[0];
            cmd_off <= 1'b1;
            cyc(3);
            outs(1'b0, 1'b0);
            @(posedge pclk);
            cmd_off <= 1'b0;
            cyc(3);
            outs(1'b1, 1'b1);
        end
        // Overheat while disabled; cleared while still above hysteresis
        @(posedge pclk);
        {cmd_off, over_temp, temp_below_hyst} <= 3'b110;
        cyc(4);
        over_temp <= 1'b0;
        apb(1'b0, hbridge_pkg::IRQ_STAT_ADDR, '0);
        chk(r[hbridge_pkg::EV_OT], 1'b1);
        chk(irq, 1'b1);
        apb(1'b1, hbridge_pkg::IRQ_CLR_ADDR, 32'hf);
        cyc(2);
        chk(irq, 1'b0);
        cmd_off <= 1'b0;
        cyc(4);
        chk({high_on_a, low_on_a, high_on_b, low_on_b}, 4'h0);
        temp_below_hyst <= 1'b1;
        cyc(3);
        outs(1'b1, 1'b1);
        // Short inside the blanking window latches, outside it does not
        for (int k = 0; k < 2; k++) begin
            @(posedge pclk);
            cmd_off <= 1'b1;
            cyc(3);
            cmd_off <= 1'b0;
            cyc(3 + k * (BLANK_C + 5));
            short_detect <= 1'b1;
            cyc(1);
            short_detect <= 1'b0;
            cyc(20);
            outs(k[0], k[0]);
        end
        // Low supply with its interrupt masked, then recovery
        apb(1'b1, hbridge_pkg::IRQ_EN_ADDR, '0);
        undervoltage <= 1'b1;
        cyc(4);
        outs(1'b0, 1'b0);
        chk(irq, 1'b0);
        @(posedge pclk);
        undervoltage <= 1'b0;
        cyc(4);
        outs(1'b1, 1'b1);
        apb(1'b1, hbridge_pkg::IRQ_EN_ADDR, 32'hf);
        cyc(2);
        chk(irq, 1'b1);
        // Limit hit opens the bridge for the off time, flag stays high
        @(posedge pclk);
        over_limit <= 1'b1;
        @(posedge pclk);
        over_limit <= 1'b0;
        cyc(3);
        outs(1'b0, 1'b1);
        v = 5;
        while ((high_on_a | low_on_a) !== 1'b1 && v < 100) begin
            @(posedge pclk);
            v++;
        end
        chk(v >= OFF_C && v <= OFF_C + 8, 1'b1);
        temp_foldback <= 1'b1;
        cyc(3);
        chk(limit_reduce, 1'b1);
        results();
    end
endmodule

`default_nettype wire
